// ===== bench/dcfs_panel_model.sv
`timescale 1ns/1ps
`default_nettype none
module dcfs_panel_model (
	// Clock
	input wire logic clk,
	// Request: origin 0 keypad, 1 terminal, 2 link
	input wire logic [1:0] org,
	input wire dcfs_pkg::dcfs_cmd_s req,
	// Command lines toward the block
	output var dcfs_pkg::dcfs_cmd_s key_cmd,
	output var dcfs_pkg::dcfs_cmd_s term_cmd,
	output var dcfs_pkg::dcfs_cmd_s mb_cmd
);
	// ==========================================================
	// Origins
	// Only the chosen origin presses; released buttons read low
	always_ff @(posedge clk) begin
		key_cmd <= (org == 2'h0) ? req : '0;
		term_cmd <= (org == 2'h1) ? req : '0;
		mb_cmd <= (org == 2'h2) ? req : '0;
	end
endmodule : dcfs_panel_model
`default_nettype wire

// ===== bench/dcfs_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin \
	check_count++; \
	if ((a) !== (e)) begin \
		bad_count++; \
		$display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); \
	end \
end
module dcfs_tb_top;
	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [2:0] start_cmd_source = 3'h4;
	logic [2:0] stop_cmd_source = 3'h4;
	logic direction_setting = 1'b0;
	logic [2:0] terminal_run_scheme = 3'h0;
	logic [1:0] cycle_speed_option = 2'h0;
	logic cfg_load = 1'b0;
	logic [1:0] org = 2'h0;
	dcfs_pkg::dcfs_cmd_s req = '0;
	dcfs_pkg::dcfs_cmd_s key_cmd, term_cmd, mb_cmd, cmd_q;
	logic mode_dir = 1'b0;
	logic scheme_run = 1'b0;
	logic scheme_dir = 1'b0;
	logic [3:0] main_freq_source = 4'ha;
	logic [2:0] aux_freq_source = 3'h1;
	logic aux_range_reference = 1'b0;
	logic [6:0] aux_range_percent = 7'h32;
	logic [2:0] freq_combine_select = 3'h0;
	logic [15:0] initial_target_freq = 16'h0100;
	logic power_down_freq_retain = 1'b0;
	logic [15:0] aux_initial_value = 16'h0000;
	logic aux_initial_polarity = 1'b0;
	logic [15:0] max_frequency = 16'h2710;
	logic power_restore = 1'b0;
	dcfs_pkg::dcfs_src_s src = '0;
	logic stage_active = 1'b0;
	logic up_key = 1'b0;
	logic down_key = 1'b0;
	logic source_switch = 1'b0;
	logic [15:0] running_freq = 16'h0155;
	logic run_q, dir_q, aux_polarity_readback, cfg_error_q;
	logic [15:0] target_freq_q, aux_value_readback;
	int bad_count = 0;
	int check_count = 0;

	// Clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	dcfs_panel_model dcfs_panel_model_i (.clk, .org, .req, .key_cmd,
		.term_cmd, .mb_cmd);
	dcfs_top dcfs_top_i (.clk, .rst_n, .start_cmd_source,
		.stop_cmd_source, .direction_setting, .terminal_run_scheme,
		.cycle_speed_option, .cfg_load, .key_cmd, .term_cmd, .mb_cmd,
		.mode_dir, .scheme_run, .scheme_dir, .main_freq_source,
		.aux_freq_source, .aux_range_reference, .aux_range_percent,
		.freq_combine_select, .initial_target_freq,
		.power_down_freq_retain, .aux_initial_value,
		.aux_initial_polarity, .max_frequency, .power_restore, .src,
		.stage_active, .up_key, .down_key, .source_switch, .running_freq,
		.run_q, .cmd_q, .dir_q, .target_freq_q, .aux_value_readback,
		.aux_polarity_readback, .cfg_error_q);

	// ==========================================================
	// Tasks
	task automatic wrap_up();
		if (bad_count == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask : cyc
	task automatic load(input logic [2:0] s, input logic [3:0] m);
		start_cmd_source = s;
		stop_cmd_source = s;
		main_freq_source = m;
		cfg_load = 1'b1;
		cyc(1);
		cfg_load = 1'b0;
		cyc(1);
	endtask : load
	task automatic send(input logic [1:0] o, input logic [4:0] c);
		org = o;
		req = c;
		cyc(2);
	endtask : send
	task automatic t_sources();
		logic acc;
		for (int o = 0; o < 3; o++) begin
			send(o[1:0], 5'h1f);
			`CHK(cmd_q, 5'h1f)
			send(o[1:0], 5'h00);
		end
		for (int s = 0; s < 5; s++) begin
			load(s[2:0], 4'ha);
			for (int o = 0; o < 3; o++) begin
				acc = (o == 0) ? (s % 2 == 0) : (o == 1) ?
					(s inside {1, 2, 4}) : (s > 2);
				send(o[1:0], 5'h1f);
				`CHK(cmd_q, acc ? 5'h1f : 5'h00)
				send(o[1:0], 5'h00);
			end
		end
		terminal_run_scheme = 3'h1;
		send(2'h0, 5'h10);
		`CHK(cmd_q, 5'h00)
		send(2'h0, 5'h00);
		terminal_run_scheme = 3'h0;
	endtask : t_sources
	task automatic t_dir();
		for (int i = 0; i < 4; i++) begin
			direction_setting = i[1];
			mode_dir = i[0];
			cyc(2);
			`CHK(dir_q, i[1] ^ i[0])
		end
		cycle_speed_option = dcfs_pkg::CYCLE_AUTO;
		mode_dir = 1'b0;
		cyc(2);
		`CHK(dir_q, 1'b0)
		cycle_speed_option = 2'h0;
		direction_setting = 1'b0;
		terminal_run_scheme = 3'h1;
		scheme_dir = 1'b1;
		scheme_run = 1'b1;
		cyc(3);
		`CHK(dir_q, 1'b1)
		`CHK(run_q, 1'b1)
		scheme_run = 1'b0;
		cyc(2);
		`CHK(run_q, 1'b0)
		terminal_run_scheme = 3'h0;
		scheme_dir = 1'b0;
	endtask : t_dir
	task automatic run_stop();
		send(2'h0, 5'h10);
		send(2'h0, 5'h00);
		`CHK(run_q, 1'b1)
		send(2'h0, 5'h08);
		send(2'h0, 5'h00);
		cyc(2);
	endtask : run_stop
	task automatic digi(input logic [3:0] m, input logic [15:0] e);
		aux_freq_source = dcfs_pkg::AUX_AN_TWO;
		load(3'h4, m);
		cyc(1);
		`CHK(target_freq_q, 16'h0100)
		up_key = 1'b1;
		cyc(3);
		up_key = 1'b0;
		cyc(2);
		`CHK(target_freq_q, 16'h0103)
		run_stop();
		`CHK(target_freq_q, e)
	endtask : digi
	task automatic pwr(input logic r, input logic [15:0] e);
		power_down_freq_retain = r;
		power_restore = 1'b1;
		cyc(1);
		power_restore = 1'b0;
		cyc(2);
		`CHK(target_freq_q, e)
	endtask : pwr
	task automatic cmb(input logic [2:0] c, input logic sw, input logic rf,
		input logic [6:0] p, input logic [15:0] x, input logic [15:0] e);
		freq_combine_select = c;
		source_switch = sw;
		aux_range_reference = rf;
		aux_range_percent = p;
		src.modbus = x;
		cyc(2);
		`CHK(target_freq_q, e)
	endtask : cmb

	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		cyc(1);
		t_sources();
		t_dir();
		digi(4'h0, 16'h0155);
		pwr(1'b0, 16'h0100);
		run_stop();
		pwr(1'b1, 16'h0155);
		digi(4'h6, 16'h0155);
		digi(4'h5, 16'h0100);
		aux_freq_source = dcfs_pkg::AUX_AN_ONE;
		src.an_one = 16'hc000;
		load(3'h4, 4'ha);
		cmb(3'h0, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0fa0);
		cmb(3'h1, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h1e46);
		cmb(3'h1, 1'b0, 1'b0, 7'h32, 16'h2328, 16'h2710);
		cmb(3'h5, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h00fa);
		cmb(3'h5, 1'b0, 1'b0, 7'h32, 16'h03e8, 16'h0000);
		cmb(3'h2, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0fa0);
		cmb(3'h2, 1'b1, 1'b0, 7'h32, 16'h0fa0, 16'h0ea6);
		cmb(3'h3, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0fa0);
		cmb(3'h3, 1'b1, 1'b0, 7'h32, 16'h0fa0, 16'h1e46);
		cmb(3'h6, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h1482);
		cmb(3'h1, 1'b0, 1'b1, 7'h32, 16'h0fa0, 16'h157c);
		cmb(3'h1, 1'b0, 1'b0, 7'h64, 16'h03e8, 16'h2134);
		cmb(3'h1, 1'b0, 1'b0, 7'h7f, 16'h03e8, 16'h2134);
		aux_freq_source = dcfs_pkg::AUX_PID;
		cmb(3'h5, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0000);
		`CHK(cfg_error_q, 1'b1)
		cmb(3'h6, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0000);
		cmb(3'h3, 1'b1, 1'b0, 7'h32, 16'h0fa0, 16'h0000);
		aux_freq_source = dcfs_pkg::AUX_AN_ONE;
		src.stage = 16'h0bb8;
		stage_active = 1'b1;
		load(3'h4, dcfs_pkg::MAIN_STAGE);
		cmb(3'h4, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0bb8);
		stage_active = 1'b0;
		cmb(3'h4, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0ea6);
		src.pid = 16'h0777;
		load(3'h4, dcfs_pkg::MAIN_PID);
		cmb(3'h0, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0777);
		aux_freq_source = dcfs_pkg::AUX_DIG_MEM;
		aux_initial_value = 16'h03e8;
		aux_initial_polarity = 1'b1;
		load(3'h4, dcfs_pkg::MAIN_MODBUS);
		cmb(3'h1, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0bb8);
		`CHK(aux_value_readback, 16'h03e8)
		`CHK(aux_polarity_readback, 1'b1)
		cmb(3'h2, 1'b1, 1'b0, 7'h32, 16'h0fa0, 16'h03e8);
		`CHK(aux_polarity_readback, 1'b0)
		cmb(3'h4, 1'b0, 1'b0, 7'h32, 16'h0fa0, 16'h0000);
		`CHK(cfg_error_q, 1'b1)
		wrap_up();
	end
	// Cuts a hang short
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		wrap_up();
	end
endmodule : dcfs_tb_top
`default_nettype wire

// ===== bench/dcfs_top_props.sv
`timescale 1ns/1ps
`default_nettype none
module dcfs_top_props #(
	parameter int FREQ_W = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Settings
	input wire logic [2:0] start_cmd_source,
	input wire logic direction_setting,
	input wire logic [2:0] terminal_run_scheme,
	input wire logic [1:0] cycle_speed_option,
	input wire logic cfg_load,
	input wire logic [3:0] main_freq_source,
	input wire logic [2:0] aux_freq_source,
	input wire logic [2:0] freq_combine_select,
	input wire logic [FREQ_W-1:0] max_frequency,
	// Inputs
	input wire dcfs_pkg::dcfs_cmd_s key_cmd,
	input wire dcfs_pkg::dcfs_cmd_s term_cmd,
	input wire dcfs_pkg::dcfs_cmd_s mb_cmd,
	input wire logic mode_dir,
	input wire dcfs_pkg::dcfs_src_s src,
	// Outputs
	input wire logic run_q,
	input wire dcfs_pkg::dcfs_cmd_s cmd_q,
	input wire logic dir_q,
	input wire logic [FREQ_W-1:0] target_freq_q,
	input wire logic cfg_error_q
);
	// ==========================================================
	// Helpers
	logic [2:0] st_q;
	logic [3:0] main_q;
	logic dir_x;
	logic [FREQ_W-1:0] mb_f;
	logic key_only;
	logic mb_only;
	// Shadow of the latched sources
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q <= 3'h4;
			main_q <= 4'h0;
		end else if (cfg_load) begin
			st_q <= start_cmd_source;
			main_q <= main_freq_source;
		end
	end
	// Derived terms
	assign dir_x = direction_setting ^ mode_dir;
	assign mb_f = src.modbus;
	assign key_only = key_cmd.start && !term_cmd.start && !mb_cmd.start;
	assign mb_only = mb_cmd.start && !key_cmd.start && !term_cmd.start;
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// ==========================================================
	// Properties
	a_scheme_blocks: assert property (
		terminal_run_scheme != 3'h0 |=> cmd_q == '0
	) else $error("command passed under a run scheme");
	a_key_gate: assert property (
		key_only && terminal_run_scheme == 3'h0
		|=> cmd_q.start == ($past(st_q) inside {3'h0, 3'h2, 3'h4})
	) else $error("keypad start gated wrongly");
	a_link_gate: assert property (
		mb_only && terminal_run_scheme == 3'h0
		|=> cmd_q.start == ($past(st_q) inside {3'h3, 3'h4})
	) else $error("link start gated wrongly");
	a_dir_xor: assert property (
		terminal_run_scheme == 3'h0 && cycle_speed_option != 2'h2
		|=> dir_q == $past(dir_x)
	) else $error("direction not the xor of its inputs");
	a_dir_auto: assert property (
		terminal_run_scheme == 3'h0 && cycle_speed_option == 2'h2
		|=> dir_q == $past(mode_dir)
	) else $error("direction setting used under auto cycle");
	a_clamp_max: assert property (
		target_freq_q <= max_frequency
	) else $error("target above maximum frequency");
	a_sub_pid: assert property (
		freq_combine_select == 3'h5 && aux_freq_source == 3'h5
		|=> cfg_error_q && target_freq_q == '0
	) else $error("pid accepted in subtract mode");
	a_link_freq: assert property (
		main_q == 4'ha && freq_combine_select == 3'h0
		&& mb_f <= max_frequency |=> target_freq_q == $past(mb_f)
	) else $error("link frequency not taken");
	a_run_start: assert property (
		$rose(cmd_q.start) && !cmd_q.stop |-> ##[0:2] run_q
	) else $error("start did not run");
	c_run: cover property ($rose(run_q));
	c_err: cover property ($rose(cfg_error_q));
	c_rev: cover property ($rose(dir_q));
endmodule : dcfs_top_props
bind dcfs_top dcfs_top_props #(.FREQ_W(FREQ_W)) dcfs_top_props_i (
	.clk, .rst_n, .start_cmd_source, .direction_setting,
	.terminal_run_scheme, .cycle_speed_option, .cfg_load,
	.main_freq_source, .aux_freq_source, .freq_combine_select,
	.max_frequency, .key_cmd, .term_cmd, .mb_cmd, .mode_dir, .src,
	.run_q, .cmd_q, .dir_q, .target_freq_q, .cfg_error_q
);
`default_nettype wire

// ===== shared/dcfs_pkg.sv
`default_nettype none
package dcfs_pkg;
	// ==========================================================
	// Widths
	localparam int FREQ_W = 16;
	localparam int PCT_W = 7;

	// ==========================================================
	// Command source codes
	localparam logic [2:0] CMD_KEYPAD = 3'h0;
	localparam logic [2:0] CMD_TERMINAL = 3'h1;
	localparam logic [2:0] CMD_KEY_TERM = 3'h2;
	localparam logic [2:0] CMD_MODBUS = 3'h3;
	localparam logic [2:0] CMD_ALL = 3'h4;
	localparam logic [2:0] CMD_SRC_RESET = 3'h4;

	// ==========================================================
	// Main source codes
	localparam logic [3:0] MAIN_DIG_MEM = 4'h0;
	localparam logic [3:0] MAIN_AN_ONE = 4'h1;
	localparam logic [3:0] MAIN_AN_TWO = 4'h2;
	localparam logic [3:0] MAIN_PULSE = 4'h3;
	localparam logic [3:0] MAIN_STAGE = 4'h4;
	localparam logic [3:0] MAIN_DIG_NOMEM = 4'h5;
	localparam logic [3:0] MAIN_PID = 4'h9;
	localparam logic [3:0] MAIN_MODBUS = 4'ha;

	// ==========================================================
	// Secondary source codes
	localparam logic [2:0] AUX_DIG_MEM = 3'h0;
	localparam logic [2:0] AUX_AN_ONE = 3'h1;
	localparam logic [2:0] AUX_AN_TWO = 3'h2;
	localparam logic [2:0] AUX_PULSE = 3'h3;
	localparam logic [2:0] AUX_STAGE = 3'h4;
	localparam logic [2:0] AUX_PID = 3'h5;

	// ==========================================================
	// Combine modes and other settings
	localparam logic [2:0] CMB_X = 3'h0;
	localparam logic [2:0] CMB_X_PLUS_Y = 3'h1;
	localparam logic [2:0] CMB_X_OR_Y = 3'h2;
	localparam logic [2:0] CMB_X_OR_XY = 3'h3;
	localparam logic [2:0] CMB_STAGE_AN = 3'h4;
	localparam logic [2:0] CMB_X_MINUS_Y = 3'h5;
	localparam logic [2:0] CMB_OFFSET = 3'h6;
	localparam logic [1:0] CYCLE_AUTO = 2'h2;
	localparam logic [6:0] PCT_FULL = 7'h64;
	localparam logic [FREQ_W-1:0] FREQ_RESET = 16'h0000;

	// ==========================================================
	// Grouped carriers
	typedef struct packed {
		logic start;
		logic stop;
		logic fwd;
		logic rev;
		logic jog;
	} dcfs_cmd_s;

	typedef struct packed {
		logic [FREQ_W-1:0] an_one;
		logic [FREQ_W-1:0] an_two;
		logic [FREQ_W-1:0] pulse;
		logic [FREQ_W-1:0] stage;
		logic [FREQ_W-1:0] pid;
		logic [FREQ_W-1:0] modbus;
	} dcfs_src_s;

	typedef enum logic [1:0] {
		DCFS_IDLE,
		DCFS_RUN
	} dcfs_run_e;
endpackage : dcfs_pkg
`default_nettype wire

// ===== src/dcfs_aux_scale.sv
`timescale 1ns/1ps
`default_nettype none
module dcfs_aux_scale #(
	parameter int FREQ_W = 16
) (
	// Span reference
	input wire logic range_ref,
	input wire logic [6:0] range_pct,
	input wire logic [FREQ_W-1:0] max_freq,
	input wire logic [FREQ_W-1:0] x_freq,
	// Raw analog value, full scale at all ones
	input wire logic [FREQ_W-1:0] raw,
	// Scaled outputs
	output logic [FREQ_W-1:0] y_max,
	output logic [FREQ_W-1:0] y_scaled
);
	logic [FREQ_W-1:0] base;
	logic [FREQ_W+6:0] prod;
	logic [2*FREQ_W-1:0] prod2;

	// Ymax from maximum frequency or from X
	always_comb begin
		base = range_ref ? x_freq : max_freq;
		prod = base * range_pct;
		y_max = FREQ_W'(prod / 7'h64);
		prod2 = y_max * raw;
		y_scaled = prod2[2*FREQ_W-1:FREQ_W];
	end
endmodule : dcfs_aux_scale
`default_nettype wire

// ===== src/dcfs_cmd_gate.sv
`timescale 1ns/1ps
`default_nettype none
module dcfs_cmd_gate (
	// Source selection
	input wire logic [2:0] src_sel,
	// Candidate commands
	input wire logic key_cmd,
	input wire logic term_cmd,
	input wire logic mb_cmd,
	// Accepted command
	output logic cmd_out
);
	// Accept a command only from the selected source set
	always_comb begin
		unique case (src_sel)
			dcfs_pkg::CMD_KEYPAD: cmd_out = key_cmd;
			dcfs_pkg::CMD_TERMINAL: cmd_out = term_cmd;
			dcfs_pkg::CMD_KEY_TERM: cmd_out = key_cmd | term_cmd;
			dcfs_pkg::CMD_MODBUS: cmd_out = mb_cmd;
			dcfs_pkg::CMD_ALL: cmd_out = key_cmd | term_cmd | mb_cmd;
			default: cmd_out = 1'b0;
		endcase
	end
endmodule : dcfs_cmd_gate
`default_nettype wire

// ===== src/dcfs_top.sv
// Function
// - Start source picks keypad, terminals, both, MODBUS or all; resets to 4.
// - Stop source uses same encoding independently; resets to 4.
// - Selected sources govern start, stop, forward, reverse and jog.
// - Both sources 3 means run commands come only from MODBUS.
// - Setting 2 or 4 accepts keypad and terminal commands together.
// - Final direction is direction setting XOR speed-mode direction.
// - Automatic circulation cycle option ignores the direction setting.
// - Main source codes 0-5, 9 PID, 10 MODBUS; default 0.
// - Retained digital starts at initial target on cfg_load (0 after reset); after stop keeps last run freq.
// - Retained target survives power loss only with retention setting 1.
// - Non-retained digital returns to initial target after every stop.
// - PID mode runs at PID value; MODBUS mode takes MODBUS frequency.
// - Secondary codes 0-5; alone it behaves like the main source.
// - Retained secondary alone starts at aux initial on cfg_load (0 after reset); polarity ignored.
// - Combine 1 or 3 with retained Y uses initial and polarity; readback.
// - Analog Y span set by range reference and percentage.
// - Range reference 0 max freq, 1 tracks X; percent 0-100.
// - Combine 0 gives X, 1 X plus Y, 5 X minus Y without PID.
// - Mode 2 switches X/Y, mode 3 X/X+Y by terminal; mode 3 without PID.
// - Mode 4 stage speed overrides analog; analog used when stage withdrawn.
// - Mode 6 gives X plus Y minus half Ymax, no PID.
// - Nonzero terminal run scheme ignores start, stop and direction settings.
`timescale 1ns/1ps
`default_nettype none
module dcfs_top #(
	parameter int FREQ_W = dcfs_pkg::FREQ_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Command settings
	input wire logic [2:0] start_cmd_source,
	input wire logic [2:0] stop_cmd_source,
	input wire logic direction_setting,
	input wire logic [2:0] terminal_run_scheme,
	input wire logic [1:0] cycle_speed_option,
	input wire logic cfg_load,
	// Command inputs by origin
	input wire dcfs_pkg::dcfs_cmd_s key_cmd,
	input wire dcfs_pkg::dcfs_cmd_s term_cmd,
	input wire dcfs_pkg::dcfs_cmd_s mb_cmd,
	input wire logic mode_dir,
	input wire logic scheme_run,
	input wire logic scheme_dir,
	// Frequency settings
	input wire logic [3:0] main_freq_source,
	input wire logic [2:0] aux_freq_source,
	input wire logic aux_range_reference,
	input wire logic [6:0] aux_range_percent,
	input wire logic [2:0] freq_combine_select,
	input wire logic [FREQ_W-1:0] initial_target_freq,
	input wire logic power_down_freq_retain,
	input wire logic [FREQ_W-1:0] aux_initial_value,
	input wire logic aux_initial_polarity,
	input wire logic [FREQ_W-1:0] max_frequency,
	input wire logic power_restore,
	// Frequency inputs
	input wire dcfs_pkg::dcfs_src_s src,
	input wire logic stage_active,
	input wire logic up_key,
	input wire logic down_key,
	input wire logic source_switch,
	input wire logic [FREQ_W-1:0] running_freq,
	// Outputs
	output logic run_q,
	output dcfs_pkg::dcfs_cmd_s cmd_q,
	output logic dir_q,
	output logic [FREQ_W-1:0] target_freq_q,
	output logic [FREQ_W-1:0] aux_value_readback,
	output logic aux_polarity_readback,
	output logic cfg_error_q
);
	// ==========================================================
	// Settings latched on cfg_load
	logic [2:0] start_src_q;
	logic [2:0] stop_src_q;
	logic [3:0] main_src_q;

	// Sources default to all origins, main source to retained digital
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			start_src_q <= dcfs_pkg::CMD_SRC_RESET;
			stop_src_q <= dcfs_pkg::CMD_SRC_RESET;
			main_src_q <= dcfs_pkg::MAIN_DIG_MEM;
		end else if (cfg_load) begin
			start_src_q <= start_cmd_source;
			stop_src_q <= stop_cmd_source;
			main_src_q <= main_freq_source;
		end
	end

	// ==========================================================
	// Command gating per command bit
	// Stop bit draws on the stop source, all others on the start source
	logic [4:0] gated;
	logic [4:0] sel_is_stop;
	assign sel_is_stop = 5'h08;

	// One gate per command bit
	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_cmd
			dcfs_cmd_gate dcfs_cmd_gate_i (
				.src_sel(sel_is_stop[gi] ? stop_src_q : start_src_q),
				.key_cmd(key_cmd[gi]),
				.term_cmd(term_cmd[gi]),
				.mb_cmd(mb_cmd[gi]),
				.cmd_out(gated[gi])
			);
		end
	endgenerate

	// Any two-line or three-line scheme takes over run control
	logic scheme_on;
	assign scheme_on = terminal_run_scheme != 3'h0;

	// Run state machine
	dcfs_pkg::dcfs_run_e state_q;
	logic stop_evt;

	// Stop request from the scheme or from the stop source
	always_comb begin
		if (scheme_on) begin
			stop_evt = (state_q == dcfs_pkg::DCFS_RUN) && !scheme_run;
		end else begin
			stop_evt = (state_q == dcfs_pkg::DCFS_RUN) && gated[3];
		end
	end

	// Idle until a start, forward, reverse or jog, run until a stop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= dcfs_pkg::DCFS_IDLE;
		end else begin
			unique case (state_q)
				dcfs_pkg::DCFS_IDLE: begin
					if (scheme_on ? scheme_run : (gated[4] | gated[2] | gated[1] | gated[0])) begin
						state_q <= dcfs_pkg::DCFS_RUN;
					end
				end
				dcfs_pkg::DCFS_RUN: begin
					if (stop_evt) begin
						state_q <= dcfs_pkg::DCFS_IDLE;
					end
				end
			endcase
		end
	end

	// Registered run and command outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			cmd_q <= '0;
		end else begin
			run_q <= (state_q == dcfs_pkg::DCFS_RUN) && !stop_evt;
			cmd_q <= scheme_on ? '0 : gated;
		end
	end

	// ==========================================================
	// Direction resolution
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dir_q <= 1'b0;
		end else if (scheme_on) begin
			dir_q <= scheme_dir;
		end else if (cycle_speed_option == dcfs_pkg::CYCLE_AUTO) begin
			dir_q <= mode_dir;
		end else begin
			dir_q <= direction_setting ^ mode_dir;
		end
	end

	// ==========================================================
	// Digital setpoints
	logic [FREQ_W-1:0] dig_q;
	logic [FREQ_W-1:0] aux_dig_q;
	logic aux_pol_q;
	logic stopped_evt;
	logic main_nomem;
	logic aux_in_combo;
	logic aux_neg;
	// Stop and combine-mode qualifiers
	assign stopped_evt = (state_q == dcfs_pkg::DCFS_RUN) && stop_evt;
	assign main_nomem = main_src_q == dcfs_pkg::MAIN_DIG_NOMEM;
	assign aux_in_combo = freq_combine_select == dcfs_pkg::CMB_X_PLUS_Y ||
		freq_combine_select == dcfs_pkg::CMB_X_OR_XY;

	// Polarity counts only for a retained Y inside modes 1 and 3
	assign aux_neg = aux_pol_q && aux_in_combo &&
		aux_freq_source == dcfs_pkg::AUX_DIG_MEM;

	// Main digital target follows keys; stop snapshots or restores
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dig_q <= dcfs_pkg::FREQ_RESET;
		end else if (power_restore) begin
			dig_q <= power_down_freq_retain ? dig_q : initial_target_freq;
		end else if (stopped_evt) begin
			dig_q <= main_nomem ? initial_target_freq : running_freq;
		end else if (cfg_load) begin
			dig_q <= initial_target_freq;
		end else if (up_key && dig_q < max_frequency) begin
			dig_q <= dig_q + 1'b1;
		end else if (down_key && dig_q != '0) begin
			dig_q <= dig_q - 1'b1;
		end
	end

	// Secondary digital value with polarity
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aux_dig_q <= dcfs_pkg::FREQ_RESET;
			aux_pol_q <= 1'b0;
		end else if (cfg_load) begin
			aux_dig_q <= aux_initial_value;
			aux_pol_q <= aux_initial_polarity;
		end
	end

	// ==========================================================
	// Source selection
	logic [FREQ_W-1:0] x_val;
	logic [FREQ_W-1:0] y_raw;
	logic [FREQ_W-1:0] y_max;
	logic [FREQ_W-1:0] y_an;
	logic y_is_an;

	// Main source X
	always_comb begin
		unique case (main_src_q)
			dcfs_pkg::MAIN_AN_ONE: x_val = src.an_one;
			dcfs_pkg::MAIN_AN_TWO: x_val = src.an_two;
			dcfs_pkg::MAIN_PULSE: x_val = src.pulse;
			dcfs_pkg::MAIN_STAGE: x_val = src.stage;
			dcfs_pkg::MAIN_PID: x_val = src.pid;
			dcfs_pkg::MAIN_MODBUS: x_val = src.modbus;
			default: x_val = dig_q;
		endcase
	end

	// Secondary source Y, flagging the analog ones
	always_comb begin
		y_is_an = 1'b0;
		unique case (aux_freq_source)
			dcfs_pkg::AUX_AN_ONE: begin
				y_raw = src.an_one;
				y_is_an = 1'b1;
			end
			dcfs_pkg::AUX_AN_TWO: begin
				y_raw = src.an_two;
				y_is_an = 1'b1;
			end
			dcfs_pkg::AUX_PULSE: y_raw = src.pulse;
			dcfs_pkg::AUX_STAGE: y_raw = src.stage;
			dcfs_pkg::AUX_PID: y_raw = src.pid;
			default: y_raw = aux_dig_q;
		endcase
	end

	dcfs_aux_scale #(.FREQ_W(FREQ_W)) dcfs_aux_scale_i (
		.range_ref(aux_range_reference),
		.range_pct(aux_range_percent > dcfs_pkg::PCT_FULL ?
			dcfs_pkg::PCT_FULL : aux_range_percent),
		.max_freq(max_frequency),
		.x_freq(x_val),
		.raw(y_raw),
		.y_max(y_max),
		.y_scaled(y_an)
	);

	// Analog Y is scaled, other sources pass unchanged
	logic [FREQ_W-1:0] y_val;
	assign y_val = y_is_an ? y_an : y_raw;

	// ==========================================================
	// Combination
	logic x_pid;
	logic y_pid;
	logic bad;
	logic signed [FREQ_W+1:0] sum;
	logic signed [FREQ_W+1:0] xs;
	logic signed [FREQ_W+1:0] ys;
	// PID flags and zero-extended signed operands; Y negated when polarity applies
	assign x_pid = main_src_q == dcfs_pkg::MAIN_PID;
	assign y_pid = aux_freq_source == dcfs_pkg::AUX_PID;
	assign xs = $signed({2'b00, x_val});
	assign ys = aux_neg ? -$signed({2'b00, y_val}) : $signed({2'b00, y_val});

	// Combine X and Y; flag illegal pairings
	always_comb begin
		bad = 1'b0;
		unique case (freq_combine_select)
			dcfs_pkg::CMB_X_PLUS_Y: sum = xs + ys;
			dcfs_pkg::CMB_X_OR_Y: sum = source_switch ? ys : xs;
			dcfs_pkg::CMB_X_OR_XY: begin
				sum = source_switch ? xs + ys : xs;
				bad = x_pid | y_pid;
			end
			dcfs_pkg::CMB_STAGE_AN: begin
				sum = stage_active ? xs : ys;
				bad = main_src_q != dcfs_pkg::MAIN_STAGE ||
					aux_freq_source != dcfs_pkg::AUX_AN_ONE;
			end
			dcfs_pkg::CMB_X_MINUS_Y: begin
				sum = xs - ys;
				bad = x_pid | y_pid;
			end
			dcfs_pkg::CMB_OFFSET: begin
				sum = xs + ys - $signed({3'b000, y_max[FREQ_W-1:1]});
				bad = x_pid | y_pid;
			end
			default: sum = xs;
		endcase
	end

	// Clamped target and readback
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			target_freq_q <= dcfs_pkg::FREQ_RESET;
			cfg_error_q <= 1'b0;
			aux_value_readback <= dcfs_pkg::FREQ_RESET;
			aux_polarity_readback <= 1'b0;
		end else begin
			if (bad) begin
				target_freq_q <= dcfs_pkg::FREQ_RESET;
			end else if (sum < 0) begin
				target_freq_q <= dcfs_pkg::FREQ_RESET;
			end else if (sum > $signed({2'b00, max_frequency})) begin
				target_freq_q <= max_frequency;
			end else begin
				target_freq_q <= sum[FREQ_W-1:0];
			end
			cfg_error_q <= bad;
			aux_value_readback <= y_val;
			aux_polarity_readback <= aux_neg;
		end
	end
endmodule : dcfs_top
`default_nettype wire
